// ===== hw/ccv_pkg.sv
// Purpose: Constants shared by the character-cell video pipeline.
// Assumes: 25 MHz dot clock, one dot per clock.
// Notes:   Offsets are AXI4-Lite byte addresses.
package ccv_pkg;
	// Line timing: 64 us line at 40 ns per clock
	localparam int LINE_TIME_NS = 64000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int LINE_CYC = LINE_TIME_NS / CLK_PERIOD_NS;
	localparam int TXT_DOTS = 10;
	localparam int HI_DOTS = 16;
	localparam logic [3:0] TXT_DLAST = 4'(TXT_DOTS - 1);
	localparam logic [3:0] HI_DLAST = 4'(HI_DOTS - 1);
	localparam logic [7:0] TXT_CELLS = 8'(LINE_CYC / TXT_DOTS);
	localparam logic [7:0] HI_CELLS = 8'(LINE_CYC / HI_DOTS);
	localparam logic [7:0] TXT_COLS = 8'h50;
	localparam logic [7:0] HI_COLS = 8'h32;
	localparam logic [8:0] ACT_LINES = 9'h190;
	localparam logic [8:0] TOT_LINES = 9'h1a0;
	localparam logic [8:0] VS_FIRST = 9'h194;
	localparam logic [8:0] VS_LAST = 9'h197;
	localparam logic [7:0] HS_OFS = 8'h08;
	localparam logic [7:0] HS_W = 8'h0c;
	localparam logic [3:0] REF_PER_LINE = 4'hf;
	localparam logic [3:0] SB_SLOT = 4'h0;
	localparam logic [3:0] SB_LATCH = 4'h1;
	localparam logic [3:0] FONT_SLOT = 4'h2;
	localparam logic [3:0] FONT_LATCH = 4'h3;
	localparam logic [3:0] CPU_FIRST = 4'h3;
	localparam logic [3:0] CPU_TAIL = 4'h4;
	localparam logic [1:0] CPU_BUSY = 2'h3;
	// Screen buffer window: bits 19..13 of the processor address
	localparam logic [6:0] SB_WIN = 7'h78;
	// Screen word fields and attribute positions inside the 5-bit attribute
	localparam int PTR_W = 11;
	localparam int AT_REV = 4;
	localparam int AT_LOW = 3;
	localparam int AT_UL = 2;
	localparam int AT_ND = 1;
	localparam int FONT_UL = 15;
	localparam int SAH_BANK = 4;
	localparam int SAH_MODE = 5;
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SAL = 8'h04;
	localparam logic [7:0] REG_SAH = 8'h08;
	localparam logic [7:0] REG_CURSOR = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [5:0] CTRL_RST = 6'h07;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ccv_pkg

// ===== hw/ccv_video.sv
// Purpose: Character-cell raster video pipeline with memory arbiter and
//          DRAM refresh, registers on AXI4-Lite.
// Assumes: Screen buffer and DRAM give read data in the cycle after the
//          address flop; processor port runs on i_clk.
// Notes:   Video lags the fetch by one cell; syncs are delayed to match.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Screen word bits 10..0 are a font pointer, 15..11 attributes.
// - Bit 15 reverse, 14 low intensity, 13 underline, 12 nondisplay.
// - Processor addresses 0x1000 bytes apart reach the same screen word.
// - Screen address starts at programmed word and wraps modulo 2048.
// - Font cell is 16 words, indexed by pointer and row 0..15.
// - Text mode shows low 10 font bits, LSB first as leftmost dot.
// - Text mode: font bit 15 with underline attribute whitens the line.
// - Nondisplay attribute suppresses the cell's dots.
// - High-resolution mode shifts 16 dots per cell, 50 by 25 cells.
// - High-resolution mode ignores underline, keeps other attributes.
// - Three brightness bits pick eight rising brightness levels.
// - Three contrast bits dim only low-intensity characters.
// - One display access per cell; processor waits off the slot.
// - Screen word latched; attributes delayed to align with video.
// - Font address from pointer, row and bank; top address bit picks bank.
// - Font word loads a 16-bit shifter, 10 or 16 dots out.
// - Video mixes dots, attributes and cursor, sent with syncs.
// - Retrace slots drive 8-bit refresh counter, column strobe off.
// - Counter advances per refresh; 15 refreshes each 64 us line.
// - Video and cursor only while the display window is active.
// - Bank select 0 starts fonts at zero, 1 at word 0x8000 (o_ram_addr bit 15).
module ccv_video (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_axi_awaddr,
	input  wire logic        i_axi_awvalid,
	output var  logic        o_axi_awready,
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	input  wire logic        i_axi_wvalid,
	output var  logic        o_axi_wready,
	output var  logic [1:0]  o_axi_bresp,
	output var  logic        o_axi_bvalid,
	input  wire logic        i_axi_bready,
	input  wire logic [7:0]  i_axi_araddr,
	input  wire logic        i_axi_arvalid,
	output var  logic        o_axi_arready,
	output var  logic [31:0] o_axi_rdata,
	output var  logic [1:0]  o_axi_rresp,
	output var  logic        o_axi_rvalid,
	input  wire logic        i_axi_rready,
	output var  logic [10:0] o_screen_word_addr,
	output var  logic        o_sb_rd,
	input  wire logic [15:0] i_sb_data,
	output var  logic [15:0] o_ram_addr,
	output var  logic        o_ras,
	output var  logic        o_cas,
	input  wire logic [15:0] i_ram_data,
	input  wire logic        i_cpu_req,
	input  wire logic [19:0] i_cpu_addr,
	output var  logic        o_cpu_go,
	output var  logic        o_cpu_wait,
	output var  logic        o_cpu_sb_sel,
	output var  logic [10:0] o_cpu_sb_word,
	output var  logic        o_video,
	output var  logic [5:0]  o_video_level,
	output var  logic        o_hsync,
	output var  logic        o_vsync,
	output var  logic        o_active_display_window,
	output var  logic        o_cursor_video,
	output var  logic        o_high_res_select,
	output var  logic        o_font_bank_select
);
	import ccv_pkg::*;

	typedef struct packed {
		logic [3:0]  d;
		logic [7:0]  col;
		logic [8:0]  line;
		logic [10:0] base;
		logic [10:0] sa;
		logic [15:0] word;
		logic [15:0] font;
		logic [15:0] shf;
		logic [4:0]  attr;
		logic        ulw, curh, act1, cur1, hs1, vs1, video, win, hrl;
		logic [5:0]  level;
		logic        hsync, vsync, curv;
		logic [10:0] sb_addr;
		logic        sb_rd;
		logic [15:0] ram_addr;
		logic        ras, cas;
		logic [7:0]  rcnt;
		logic [3:0]  rlin;
		logic [1:0]  cbusy;
		logic        cpu_go, cpu_wait, cpu_sb;
		logic [10:0] cpu_word;
		logic        aw_got, w_got;
		logic [7:0]  awa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        awrdy, wrdy, bv;
		logic [1:0]  bresp;
		logic        ardy, rv;
		logic [31:0] rd;
		logic [1:0]  rresp;
		logic [5:0]  ctl;
		logic [7:0]  sal;
		logic [5:0]  sah;
		logic [10:0] cur;
	} ccv_st_s;

	localparam ccv_st_s ST_RST = '{ctl: CTRL_RST, default: '0};

	ccv_st_s     st_reg;
	ccv_st_s     st_next;
	logic        hr, last, eol, fa, hs, ul, dv, start;
	logic [3:0]  dlast;
	logic [7:0]  cols, ctot;
	logic [5:0]  lvl;

	// Mode, cell geometry and fetch window
	always_comb begin
		hr = st_reg.hrl; // Mode taken at line end only
		dlast = hr ? HI_DLAST : TXT_DLAST;
		cols = hr ? HI_COLS : TXT_COLS;
		ctot = hr ? HI_CELLS : TXT_CELLS;
		last = (st_reg.d == dlast);
		eol = last && (st_reg.col == 8'(ctot - 8'h01));
		fa = (st_reg.col < cols) && (st_reg.line < ACT_LINES);
		hs = (st_reg.col >= 8'(cols + HS_OFS)) && (st_reg.col < 8'(cols + HS_OFS + HS_W));
		ul = st_reg.ulw && st_reg.attr[AT_UL] && !hr;
		dv = (st_reg.shf[0] | ul) & ~st_reg.attr[AT_ND];
		dv = dv ^ st_reg.attr[AT_REV];
		dv = (dv | st_reg.cur1) & st_reg.act1;
		lvl = {st_reg.ctl[2:0], 3'h7};
		if (st_reg.attr[AT_LOW]) begin
			lvl = 6'(lvl - {3'h0, st_reg.ctl[5:3]});
		end
		start = i_cpu_req && (st_reg.cbusy == 2'h0) && (st_reg.d >= CPU_FIRST)
			&& (st_reg.d <= 4'(dlast - CPU_TAIL));
	end

	// Next state of the whole block
	always_comb begin
		st_next = st_reg;
		// Dot, cell and line counters
		st_next.d = last ? 4'h0 : 4'(st_reg.d + 4'h1);
		if (last) begin
			st_next.col = eol ? 8'h00 : 8'(st_reg.col + 8'h01);
		end
		// Screen buffer read slot, circular address
		st_next.sb_rd = 1'b0;
		if (st_reg.d == SB_SLOT && fa) begin
			st_next.sb_addr = st_reg.sa;
			st_next.sb_rd = 1'b1;
			st_next.sa = 11'(st_reg.sa + 11'h001);
			st_next.curh = (st_reg.sa == st_reg.cur);
		end
		if (st_reg.d == SB_LATCH && st_reg.sb_rd) begin
			st_next.word = i_sb_data;
		end
		// DRAM slot: font fetch in display, refresh in retrace
		st_next.ras = 1'b0;
		st_next.cas = 1'b0;
		if (st_reg.d == FONT_SLOT) begin
			if (fa) begin
				st_next.ram_addr = {st_reg.sah[SAH_BANK], st_reg.word[PTR_W-1:0],
					st_reg.line[3:0]};
				st_next.ras = 1'b1;
				st_next.cas = 1'b1;
			end else if (st_reg.rlin < REF_PER_LINE) begin
				st_next.ram_addr = {8'h00, st_reg.rcnt};
				st_next.ras = 1'b1;
				st_next.rcnt = 8'(st_reg.rcnt + 8'h01);
				st_next.rlin = 4'(st_reg.rlin + 4'h1);
			end
		end
		if (st_reg.d == FONT_LATCH && st_reg.cas) begin
			st_next.font = i_ram_data;
		end
		// Cell boundary: reload shifter, pass attributes and flags
		if (last) begin
			st_next.shf = st_reg.font;
			st_next.attr = st_reg.word[15:11];
			st_next.ulw = st_reg.font[FONT_UL];
			st_next.act1 = fa;
			st_next.cur1 = st_reg.curh && fa;
			st_next.hs1 = hs;
			st_next.vs1 = (st_reg.line >= VS_FIRST) && (st_reg.line <= VS_LAST);
		end else begin
			st_next.shf = {1'b0, st_reg.shf[15:1]};
		end
		// Line end: row base, frame restart
		if (eol) begin
			st_next.rlin = 4'h0;
			st_next.hrl = st_reg.sah[SAH_MODE];
			if (st_reg.line == 9'(TOT_LINES - 9'h001)) begin
				st_next.line = 9'h000;
				st_next.base = {st_reg.sah[2:0], st_reg.sal};
				st_next.sa = {st_reg.sah[2:0], st_reg.sal};
			end else begin
				st_next.line = 9'(st_reg.line + 9'h001);
				if (st_reg.line[3:0] == 4'hf) begin
					st_next.base = st_reg.sa;
				end else begin
					st_next.sa = st_reg.base;
				end
			end
		end
		// Video mix and intensity
		st_next.video = dv;
		st_next.level = dv ? lvl : 6'h00;
		st_next.hsync = st_reg.hs1;
		st_next.vsync = st_reg.vs1;
		st_next.curv = st_reg.cur1 && st_reg.act1;
		st_next.win = st_reg.act1; // Window aligned with video
		// Processor arbiter
		st_next.cpu_go = start;
		st_next.cpu_wait = i_cpu_req && !start;
		if (start) begin
			st_next.cbusy = CPU_BUSY;
			st_next.cpu_sb = (i_cpu_addr[19:13] == SB_WIN);
			st_next.cpu_word = i_cpu_addr[11:1];
		end else if (st_reg.cbusy != 2'h0) begin
			st_next.cbusy = 2'(st_reg.cbusy - 2'h1);
		end
		// AXI write channels, either order
		if (i_axi_awvalid && st_reg.awrdy) begin
			st_next.aw_got = 1'b1;
			st_next.awa = i_axi_awaddr;
		end
		if (i_axi_wvalid && st_reg.wrdy) begin
			st_next.w_got = 1'b1;
			st_next.wd = i_axi_wdata;
			st_next.ws = i_axi_wstrb;
		end
		if (st_reg.bv && i_axi_bready) begin
			st_next.bv = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bv) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bv = 1'b1;
			st_next.bresp = RESP_OK;
			unique case (st_reg.awa)
				REG_CTRL: if (st_reg.ws[0]) st_next.ctl = st_reg.wd[5:0];
				REG_SAL: if (st_reg.ws[0]) st_next.sal = st_reg.wd[7:0];
				REG_SAH: if (st_reg.ws[0]) st_next.sah = st_reg.wd[5:0];
				REG_CURSOR: begin
					if (st_reg.ws[0]) st_next.cur[7:0] = st_reg.wd[7:0];
					if (st_reg.ws[1]) st_next.cur[10:8] = st_reg.wd[10:8];
				end
				REG_STATUS: st_next.bresp = RESP_OK;
				default: st_next.bresp = RESP_SLVERR;
			endcase
		end
		st_next.awrdy = !st_next.aw_got && !st_next.bv;
		st_next.wrdy = !st_next.w_got && !st_next.bv;
		// AXI read channel
		if (st_reg.rv && i_axi_rready) begin
			st_next.rv = 1'b0;
		end
		if (i_axi_arvalid && st_reg.ardy) begin
			st_next.rv = 1'b1;
			st_next.rresp = RESP_OK;
			unique case (i_axi_araddr)
				REG_CTRL: st_next.rd = {26'h0, st_reg.ctl};
				REG_SAL: st_next.rd = {24'h0, st_reg.sal};
				REG_SAH: st_next.rd = {26'h0, st_reg.sah};
				REG_CURSOR: st_next.rd = {21'h0, st_reg.cur};
				REG_STATUS: st_next.rd = {7'h0, st_reg.act1, st_reg.rcnt, 7'h0, st_reg.line};
				default: begin
					st_next.rd = 32'h0000_0000;
					st_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		st_next.ardy = !st_next.rv;
	end

	// State register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign o_axi_awready = st_reg.awrdy;
	assign o_axi_wready = st_reg.wrdy;
	assign o_axi_bresp = st_reg.bresp;
	assign o_axi_bvalid = st_reg.bv;
	assign o_axi_arready = st_reg.ardy;
	assign o_axi_rdata = st_reg.rd;
	assign o_axi_rresp = st_reg.rresp;
	assign o_axi_rvalid = st_reg.rv;
	assign o_screen_word_addr = st_reg.sb_addr;
	assign o_sb_rd = st_reg.sb_rd;
	assign o_ram_addr = st_reg.ram_addr;
	assign o_ras = st_reg.ras;
	assign o_cas = st_reg.cas;
	assign o_cpu_go = st_reg.cpu_go;
	assign o_cpu_wait = st_reg.cpu_wait;
	assign o_cpu_sb_sel = st_reg.cpu_sb;
	assign o_cpu_sb_word = st_reg.cpu_word;
	assign o_video = st_reg.video;
	assign o_video_level = st_reg.level;
	assign o_hsync = st_reg.hsync;
	assign o_vsync = st_reg.vsync;
	assign o_active_display_window = st_reg.win;
	assign o_cursor_video = st_reg.curv;
	assign o_high_res_select = st_reg.sah[SAH_MODE];
	assign o_font_bank_select = st_reg.sah[SAH_BANK];

	// Checks on the pipeline
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence sb_fetch_s;
		st_reg.sb_rd;
	endsequence
	sequence font_fetch_s;
		st_reg.ras && st_reg.cas;
	endsequence

	fetch_order_a: assert property (sb_fetch_s |-> ##2 font_fetch_s)
		else $error("font fetch did not follow screen read");
	refresh_addr_a: assert property (st_reg.ras && !st_reg.cas
		|-> st_reg.ram_addr[15:8] == 8'h00 && !$past(fa))
		else $error("refresh cycle with bad address or in display");
	refresh_count_a: assert property (st_reg.ras && !st_reg.cas
		|-> st_reg.rcnt == 8'($past(st_reg.rcnt) + 8'h01))
		else $error("refresh counter did not advance");
	refresh_limit_a: assert property (st_reg.rlin <= REF_PER_LINE)
		else $error("more refreshes than allowed in a line");
	font_row_a: assert property (font_fetch_s
		|-> st_reg.ram_addr[3:0] == st_reg.line[3:0])
		else $error("font row bits wrong");
	cpu_slot_a: assert property (st_reg.cpu_go |-> st_reg.d >= CPU_TAIL)
		else $error("processor cycle started on display slot");
	sb_alias_a: assert property (st_reg.cpu_go
		|-> st_reg.cpu_word == $past(i_cpu_addr[11:1]))
		else $error("screen word alias decode wrong");
	blank_video_a: assert property (!st_reg.act1 |=> !st_reg.video && !st_reg.curv)
		else $error("video outside display window");
	nondisp_a: assert property (st_reg.act1 && st_reg.attr[AT_ND] && !st_reg.attr[AT_REV]
		&& !st_reg.cur1 |=> !st_reg.video)
		else $error("nondisplay cell visible");
	dark_level_a: assert property (!st_reg.video |-> st_reg.level == 6'h00)
		else $error("level without video");
	video_window_a: assert property (st_reg.video |-> st_reg.win)
		else $error("video while window output low");
endmodule : ccv_video

`default_nettype wire

// ===== sim/ccv_mem_model.sv
// Purpose: Screen buffer and font DRAM model facing the video pipeline.
// Assumes: Asynchronous read; contents follow a pattern select.
// Notes:   Released data lines show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module ccv_mem_model (
	input  wire logic        i_clk,
	input  wire logic [2:0]  i_mode,
	input  wire logic [10:0] i_word_addr,
	input  wire logic        i_sb_rd,
	output logic      [15:0] o_sb_data,
	input  wire logic        i_ras,
	input  wire logic        i_cas,
	output logic      [15:0] o_ram_data
);
	// Patterns: nondisplay, reverse, low+reverse, underline, plain
	localparam logic [4:0]  ATTR [5] = '{5'h02, 5'h10, 5'h18, 5'h04, 5'h00};
	localparam logic [15:0] FONT [5] = '{16'h03ff, 16'h0000, 16'h0000, 16'h8000, 16'h0001};
	logic [15:0] sb_last  = 16'h0000;
	logic [15:0] ram_last = 16'h0000;
	// Screen word and font word; the same font word in both banks
	assign o_sb_data  = i_sb_rd ? {ATTR[i_mode], i_word_addr ^ 11'h2a5} : ~sb_last;
	assign o_ram_data = (i_ras && i_cas) ? FONT[i_mode] : ~ram_last;
	// Remember last words driven
	always_ff @(posedge i_clk) begin
		if (i_sb_rd)
			sb_last <= o_sb_data;
		if (i_ras && i_cas)
			ram_last <= o_ram_data;
	end
endmodule : ccv_mem_model
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the character-cell video pipeline.
// Assumes: Registers over AXI4-Lite, memories from the partner model.
// Notes:   Line-level counts of dots, cursor and refresh cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module testbench;
	import ccv_pkg::*;
	logic        i_clk = 1'b0, i_resetn = 1'b0, i_cpu_req = 1'b0;
	logic        i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
	logic        i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
	logic [7:0]  i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
	logic [31:0] i_axi_wdata = 32'h0000_0000;
	logic [19:0] i_cpu_addr = 20'h0_0000;
	logic [15:0] i_sb_data, i_ram_data, o_ram_addr;
	logic [10:0] o_screen_word_addr, o_cpu_sb_word, lptr;
	logic [31:0] o_axi_rdata, rd;
	logic [1:0]  o_axi_bresp, o_axi_rresp, rr;
	logic [5:0]  o_video_level, lvl_exp;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
	logic        o_sb_rd, o_ras, o_cas, o_cpu_go, o_cpu_sb_sel, o_video, o_cursor_video;
	logic        o_active_display_window, o_high_res_select, o_font_bank_select, fv;
	logic        pw = 1'b0, lvl_on = 1'b0;
	logic        o_cpu_wait, o_hsync, o_vsync, rq = 1'b0, hm = 1'b0;
	logic [2:0]  mode = 3'h0;
	logic [7:0]  rexp = 8'h00;
	int          fails = 0, comparisons = 0, nf = 0, nref = 0, gap = 99, nv, nc, nhs = 0;
	localparam logic [5:0]  LV_CTRL [4] = '{6'h07, 6'h2b, 6'h2b, 6'h00};
	localparam logic [2:0]  LV_MODE [4] = '{3'h1, 3'h1, 3'h2, 3'h2};
	localparam logic [5:0]  LV_EXP  [4] = '{6'h3f, 6'h1f, 6'h1a, 6'h07};
	localparam logic [19:0] CPU_A   [4] = '{20'hf_0002, 20'hf_1002, 20'hf_2000, 20'h0_0ffe};
	localparam logic        CPU_S   [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	// 25 MHz clock
	always #20 i_clk = ~i_clk;
	ccv_video dut_u (
		.i_clk, .i_resetn, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
		.i_axi_wstrb(4'hf), .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
		.i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata,
		.o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .o_screen_word_addr, .o_sb_rd,
		.i_sb_data, .o_ram_addr, .o_ras, .o_cas, .i_ram_data, .i_cpu_req, .i_cpu_addr,
		.o_cpu_go, .o_cpu_wait, .o_cpu_sb_sel, .o_cpu_sb_word, .o_video, .o_video_level,
		.o_hsync, .o_vsync, .o_active_display_window, .o_cursor_video,
		.o_high_res_select, .o_font_bank_select
	);
	ccv_mem_model mem_u (
		.i_clk, .i_mode(mode), .i_word_addr(o_screen_word_addr), .i_sb_rd(o_sb_rd),
		.o_sb_data(i_sb_data), .i_ras(o_ras), .i_cas(o_cas), .o_ram_data(i_ram_data)
	);
	// Stream monitor: font addresses, refresh, window gating, processor spacing
	always @(posedge i_clk) begin
		if (i_resetn) begin
			gap++;
			if (o_sb_rd)
				lptr = o_screen_word_addr ^ 11'h2a5;
			if (o_ras && o_cas)
				`CHK("font_addr", {lptr, 4'(nf)}, o_ram_addr[14:0])
			if (o_ras && !o_cas) begin
				`CHK("refresh_addr", {8'h00, rexp}, o_ram_addr)
				rexp++;
				nref++;
			end
			if (o_hsync) begin
				nhs++;
				`CHK("hsync_gate", 1'b0, o_active_display_window)
			end
			if (pw && !o_active_display_window) begin
				if (nf > 0)
					`CHK("refresh_count", 15, nref)
				if (nf > 0 && !hm)
					`CHK("hsync_width", int'(HS_W) * TXT_DOTS, nhs)
				`CHK("vsync_idle", 1'b0, o_vsync)
				nref = 0;
				nhs = 0;
				nf++;
			end
			if (o_video)
				`CHK("video_gate", 1'b1, o_active_display_window)
			if (o_video && lvl_on)
				`CHK("level", lvl_exp, o_video_level)
			if (o_cursor_video)
				`CHK("cursor_gate", 1'b1, o_active_display_window)
			if (o_cpu_go) begin
				`CHK("go_gap", 1'b1, 1'(gap >= 4))
				gap = 0;
			end
			if (rq)
				`CHK("cpu_wait", !o_cpu_go, o_cpu_wait)
			rq = i_cpu_req;
			pw = o_active_display_window;
		end
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge i_clk);
		i_axi_awaddr <= a;
		i_axi_wdata <= d;
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid <= 1'b1;
		i_axi_bready <= 1'b1;
		forever begin
			@(posedge i_clk);
			if (o_axi_awready)
				i_axi_awvalid <= 1'b0;
			if (o_axi_wready)
				i_axi_wvalid <= 1'b0;
			if (o_axi_bvalid)
				break;
		end
		i_axi_bready <= 1'b0;
		`CHK("bresp", er, o_axi_bresp)
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge i_clk);
		i_axi_araddr <= a;
		i_axi_arvalid <= 1'b1;
		i_axi_rready <= 1'b1;
		forever begin
			@(posedge i_clk);
			if (o_axi_arready)
				i_axi_arvalid <= 1'b0;
			if (o_axi_rvalid)
				break;
		end
		rd = o_axi_rdata;
		rr = o_axi_rresp;
		i_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		`CHK("rdata", e, rd)
		`CHK("rresp", RESP_OK, rr)
	endtask : rd_chk
	// One display window: dots, cursor dots, first dot
	task automatic count_line();
		nv = 0;
		nc = 0;
		do @(posedge i_clk); while (o_active_display_window);
		do @(posedge i_clk); while (!o_active_display_window);
		fv = o_video;
		while (o_active_display_window) begin
			nv += int'(o_video);
			nc += int'(o_cursor_video);
			@(posedge i_clk);
		end
	endtask : count_line
	task automatic test_done();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// Watchdog, about 40 lines of video
	initial begin
		repeat (64000) @(posedge i_clk);
		fails++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_clk);
		// Reset values, unmapped read and write
		rd_chk(REG_CTRL, 32'h0000_0007);
		rd_chk(REG_SAL, 32'h0000_0000);
		rd_chk(REG_SAH, 32'h0000_0000);
		axi_rd(8'h14);
		`CHK("unmapped_resp", RESP_SLVERR, rr)
		axi_wr(8'h14, 32'h0000_00ff, RESP_SLVERR);
		axi_wr(REG_CURSOR, 32'h0000_07ff, RESP_OK);
		rd_chk(REG_CURSOR, 32'h0000_07ff);
		// Hidden cells, then cursor on word 5
		count_line();
		`CHK("nondisplay_dots", 0, nv)
		axi_wr(REG_CURSOR, 32'h0000_0005, RESP_OK);
		count_line();
		`CHK("cursor_dots", 10, nc)
		`CHK("cursor_video", 10, nv)
		axi_wr(REG_CURSOR, 32'h0000_07ff, RESP_OK);
		// Underlined white lines, then single leftmost dot
		mode = 3'h3;
		count_line();
		`CHK("underline_dots", 800, nv)
		mode = 3'h4;
		count_line();
		`CHK("plain_dots", 80, nv)
		`CHK("first_dot", 1'b1, fv)
		// Reverse cells over brightness and contrast settings
		for (int i = 0; i < 4; i++) begin
			axi_wr(REG_CTRL, {26'h000_0000, LV_CTRL[i]}, RESP_OK);
			mode = LV_MODE[i];
			lvl_exp = LV_EXP[i];
			lvl_on = 1'b1;
			count_line();
			lvl_on = 1'b0;
			`CHK("reverse_dots", 800, nv)
		end
		// Processor cycles inside and outside the screen window
		for (int i = 0; i < 4; i++) begin
			i_cpu_req <= 1'b1;
			i_cpu_addr <= CPU_A[i];
			do @(posedge i_clk); while (!o_cpu_go);
			i_cpu_req <= 1'b0;
			repeat (2) @(posedge i_clk);
			`CHK("cpu_sel", CPU_S[i], o_cpu_sb_sel)
			if (CPU_S[i])
				`CHK("cpu_word", CPU_A[i][11:1], o_cpu_sb_word)
		end
		// Mode and bank select lines
		axi_wr(REG_SAH, 32'h0000_0030, RESP_OK);
		repeat (2) @(posedge i_clk);
		`CHK("high_res_select_sel", 1'b1, o_high_res_select)
		`CHK("bank_sel", 1'b1, o_font_bank_select)
		// Sixteen-dot cells, underline ignored: one dot per cell
		mode = 3'h3;
		hm = 1'b1;
		count_line();
		`CHK("high_res_select_dots", 50, nv)
		test_done();
	end
endmodule : testbench
`default_nettype wire
